// ### pkg/rtc_pkg.sv
// Constants, register map and state types for the real-time clock timer.
// Assumes one 100 MHz clock and an AHB-Lite slave port with 32-bit data.
package rtc_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] RTC_SECONDS_OFS  = 8'h00;
    localparam logic [7:0] RTC_MINUTES_OFS  = 8'h04;
    localparam logic [7:0] RTC_HOURS_OFS    = 8'h08;
    localparam logic [7:0] RTC_WEEKDAY_OFS  = 8'h0C;
    localparam logic [7:0] RTC_CTRL1_OFS    = 8'h10;
    localparam logic [7:0] RTC_CTRL2_OFS    = 8'h14;
    localparam logic [7:0] RTC_SRCSEL_OFS   = 8'h18;
    localparam logic [7:0] RTC_IRQSTAT_OFS  = 8'h1C;
    localparam logic [7:0] RTC_IRQMASK_OFS  = 8'h20;

    // ==========================================================
    // First control register fields
    localparam int CTRL1_START_BIT  = 0;
    localparam int CTRL1_STATUS_BIT = 1;
    localparam int CTRL1_H12_BIT    = 2;
    localparam int CTRL1_PM_BIT     = 3;
    localparam int CTRL1_INTSEL_BIT = 4;
    localparam int CTRL1_BUSY_BIT   = 5;
    // Second control register: bit 0 enables the periodic interrupt
    localparam int CTRL2_IRQEN_BIT  = 0;
    // Interrupt status bits
    localparam int IRQ_TICK_BIT     = 0;
    localparam int IRQ_STATE_BIT    = 1;
    localparam int IRQ_WIDTH        = 2;

    // ==========================================================
    // Timing
    localparam int  CLK_HZ          = 100_000_000;
    localparam int  SRC_DIV_DEFAULT = 3052;     // ~32.768 kHz count source
    localparam int  SRC_PER_SEC     = 32768;    // Count-source cycles per second
    localparam real BUSY_TIME_MS    = 62.5;
    localparam int  BUSY_SRC_CYC    = int'(BUSY_TIME_MS * SRC_PER_SEC / 1000.0);
    localparam int  SYNC_SRC_CYC    = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CTRL1_RESET  = 8'h00;
    localparam logic [7:0] SRCSEL_RESET = 8'h00;

    typedef enum logic [1:0] {RUN_STOPPED, RUN_STARTING, RUN_COUNTING, RUN_STOPPING} rtc_run_e;
endpackage

// ### rtl/rtc_timer.sv
// Real-time clock timer: seconds, minutes, hours, weekday, AHB-Lite registers.
// Assumes a single 100 MHz clock, synchronous reset and one AHB-Lite master.
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
module rtc_timer #(
    parameter int SRC_DIV = rtc_pkg::SRC_DIV_DEFAULT,   // Clocks per count-source cycle
    parameter int SRC_SEC = rtc_pkg::SRC_PER_SEC,       // Count-source cycles per second
    parameter int BUSY_CYC = rtc_pkg::BUSY_SRC_CYC      // Count-source cycles of busy
) (
    input  wire logic        CLK,         // 100 MHz clock
    input  wire logic        RST,         // Synchronous reset, high
    input  wire logic        HSEL,        // Slave select
    input  wire logic [7:0]  HADDR,       // Byte address
    input  wire logic [1:0]  HTRANS,      // Transfer type
    input  wire logic        HWRITE,      // Write when high
    input  wire logic [2:0]  HSIZE,       // Word only
    input  wire logic        HREADY,      // Bus ready in
    input  wire logic [31:0] HWDATA,      // Write data
    output logic      [31:0] HRDATA,      // Read data
    output logic             HREADYOUT,   // Always ready
    output logic             HRESP,       // Always OKAY
    output logic             IRQ          // Level interrupt
);
    import rtc_pkg::*;

    typedef struct packed {
        logic        aphase;
        logic        awrite;
        logic [7:0]  aaddr;
        logic [31:0] rdata;
        logic [5:0]  sec;
        logic [5:0]  min;
        logic [4:0]  hour;
        logic [2:0]  wday;
        logic        start;
        logic        status;
        logic        h12;
        logic        pm;
        logic        intsel;
        logic        irqen;
        logic [3:0]  srcsel;
        logic [IRQ_WIDTH-1:0] ist;
        logic [IRQ_WIDTH-1:0] imask;
        logic        irq;
        rtc_run_e    run;
        logic [1:0]  sync_cnt;
        logic [15:0] div_cnt;
        logic [15:0] sub_cnt;
        logic [15:0] busy_cnt;
        logic        busy;
    } rtc_state_s;

    rtc_state_s s_q;
    rtc_state_s s_d;

    // ==========================================================
    // Combinational next state
    always_comb begin
        logic src_tick;
        logic sec_tick;
        logic addr_ok;
        logic [IRQ_WIDTH-1:0] ev;
        logic [31:0] rd;
        s_d      = s_q;
        src_tick = 1'b0;
        sec_tick = 1'b0;
        ev       = '0;
        rd       = 32'h0000_0000;
        addr_ok  = 1'b0;

        // Count-source enable from divider
        if (s_q.div_cnt == 16'(SRC_DIV - 1)) begin
            s_d.div_cnt = 16'h0000;
            src_tick    = 1'b1;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 16'h0001;
        end

        // Start/stop handshake, two count-source edges
        unique case (s_q.run)
            RUN_STOPPED: if (s_q.start) begin
                s_d.run = RUN_STARTING;
                s_d.sync_cnt = 2'(SYNC_SRC_CYC);
            end
            RUN_STARTING: if (src_tick) begin
                if (s_q.sync_cnt == 2'h1) begin
                    s_d.run    = RUN_COUNTING;
                    s_d.status = 1'b1;
                    ev[IRQ_STATE_BIT] = 1'b1;
                end
                s_d.sync_cnt = s_q.sync_cnt - 2'h1;
            end
            RUN_COUNTING: if (!s_q.start) begin
                s_d.run = RUN_STOPPING;
                s_d.sync_cnt = 2'(SYNC_SRC_CYC);
            end
            RUN_STOPPING: if (src_tick) begin
                if (s_q.sync_cnt == 2'h1) begin
                    s_d.run    = RUN_STOPPED;
                    s_d.status = 1'b0;
                    s_d.busy   = 1'b0;
                    ev[IRQ_STATE_BIT] = 1'b1;
                end
                s_d.sync_cnt = s_q.sync_cnt - 2'h1;
            end
        endcase

        // Time base: counts only while status flag is high
        if (s_q.status && src_tick) begin
            if (s_q.sub_cnt == 16'(SRC_SEC - 1)) begin
                s_d.sub_cnt = 16'h0000;
                sec_tick    = 1'b1;
            end else begin
                s_d.sub_cnt = s_q.sub_cnt + 16'h0001;
            end
            // Busy window leads the update, so the new time lands as it drops
            if (s_q.sub_cnt == 16'(SRC_SEC - BUSY_CYC - 1)) begin
                s_d.busy     = 1'b1;
                s_d.busy_cnt = 16'(BUSY_CYC);
            end else if (s_q.busy) begin
                s_d.busy_cnt = s_q.busy_cnt - 16'h0001;
                if (s_q.busy_cnt == 16'h0001) begin
                    s_d.busy = 1'b0;
                end
            end
        end

        // All fields update in the same cycle; a read pair spanning it mismatches
        if (sec_tick) begin
            s_d.sec = s_q.sec + 6'h01;
            if (s_q.sec == 6'd59) begin
                s_d.sec = 6'h00;
                s_d.min = s_q.min + 6'h01;
                if (s_q.min == 6'd59) begin
                    s_d.min  = 6'h00;
                    s_d.hour = s_q.hour + 5'h01;
                    if (s_q.h12 && s_q.hour == 5'd11) begin
                        s_d.hour = 5'h00;
                        s_d.pm   = ~s_q.pm;
                        if (s_q.pm) begin
                            s_d.wday = (s_q.wday == 3'd6) ? 3'h0 : s_q.wday + 3'h1;
                        end
                    end else if (!s_q.h12 && s_q.hour == 5'd23) begin
                        s_d.hour = 5'h00;
                        s_d.wday = (s_q.wday == 3'd6) ? 3'h0 : s_q.wday + 3'h1;
                    end
                end
            end
            // Interrupt select: every second or every minute
            if (s_q.irqen && (!s_q.intsel || s_q.sec == 6'd59)) begin
                ev[IRQ_TICK_BIT] = 1'b1;
            end
        end

        // AHB-Lite: zero-wait, data phase one cycle after address phase
        s_d.aphase = HSEL && HREADY && HTRANS[1];
        s_d.awrite = HWRITE;
        s_d.aaddr  = HADDR;

        // Read data for next data phase
        unique case (HADDR)
            RTC_SECONDS_OFS: begin rd[5:0] = s_q.sec; addr_ok = 1'b1; end
            RTC_MINUTES_OFS: begin rd[5:0] = s_q.min; addr_ok = 1'b1; end
            RTC_HOURS_OFS:   begin rd[4:0] = s_q.hour; addr_ok = 1'b1; end
            RTC_WEEKDAY_OFS: begin rd[2:0] = s_q.wday; addr_ok = 1'b1; end
            RTC_CTRL1_OFS: begin
                rd[CTRL1_START_BIT]  = s_q.start;
                rd[CTRL1_STATUS_BIT] = s_q.status;
                rd[CTRL1_H12_BIT]    = s_q.h12;
                rd[CTRL1_PM_BIT]     = s_q.pm;
                rd[CTRL1_INTSEL_BIT] = s_q.intsel;
                rd[CTRL1_BUSY_BIT]   = s_q.busy;
                addr_ok = 1'b1;
            end
            RTC_CTRL2_OFS:   begin rd[CTRL2_IRQEN_BIT] = s_q.irqen; addr_ok = 1'b1; end
            RTC_SRCSEL_OFS:  begin rd[3:0] = s_q.srcsel; addr_ok = 1'b1; end
            RTC_IRQSTAT_OFS: begin rd[IRQ_WIDTH-1:0] = s_q.ist; addr_ok = 1'b1; end
            RTC_IRQMASK_OFS: begin rd[IRQ_WIDTH-1:0] = s_q.imask; addr_ok = 1'b1; end
            default:         rd = 32'h0000_0000;
        endcase
        if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
            s_d.rdata = addr_ok ? rd : 32'h0000_0000;
        end

        // Writes in data phase; time/config writes are honoured as given
        if (s_q.aphase && s_q.awrite) begin
            unique case (s_q.aaddr)
                RTC_SECONDS_OFS: s_d.sec  = HWDATA[5:0];
                RTC_MINUTES_OFS: s_d.min  = HWDATA[5:0];
                RTC_HOURS_OFS:   s_d.hour = HWDATA[4:0];
                RTC_WEEKDAY_OFS: s_d.wday = HWDATA[2:0];
                RTC_CTRL1_OFS: begin
                    s_d.start  = HWDATA[CTRL1_START_BIT];
                    s_d.h12    = HWDATA[CTRL1_H12_BIT];
                    s_d.pm     = HWDATA[CTRL1_PM_BIT];
                    s_d.intsel = HWDATA[CTRL1_INTSEL_BIT];
                end
                RTC_CTRL2_OFS:   s_d.irqen  = HWDATA[CTRL2_IRQEN_BIT];
                RTC_SRCSEL_OFS:  s_d.srcsel = HWDATA[3:0];
                RTC_IRQSTAT_OFS: s_d.ist    = s_q.ist & ~HWDATA[IRQ_WIDTH-1:0];
                RTC_IRQMASK_OFS: s_d.imask  = HWDATA[IRQ_WIDTH-1:0];
                default: ;
            endcase
        end

        // Set wins over write-one-to-clear
        s_d.ist = s_d.ist | ev;
        s_d.irq = |(s_d.ist & s_d.imask);
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK) begin
        if (RST) begin
            s_q        <= '0;
            s_q.run    <= RUN_STOPPED;
        end else begin
            s_q <= s_d;
        end
    end

    assign HRDATA    = s_q.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign IRQ       = s_q.irq;
endmodule

// ### dv/rtc_timer_assertions.sv
// Checker for bus answers, start/stop status and interrupt gating.
// Assumes only the top-level ports; bound at the foot of this file.
module rtc_timer_assertions
    import rtc_pkg::*;
#(parameter int SRC_DIV = 2) (
    input wire logic        CLK,       // Clock
    input wire logic        RST,       // Sync reset
    input wire logic        HSEL,      // Select
    input wire logic [7:0]  HADDR,     // Address
    input wire logic [1:0]  HTRANS,    // Transfer type
    input wire logic        HWRITE,    // Direction
    input wire logic [31:0] HWDATA,    // Write data
    input wire logic [31:0] HRDATA,    // Read data
    input wire logic        HREADYOUT, // Ready
    input wire logic        HRESP,     // Response
    input wire logic        IRQ        // Interrupt
);
    // Worst start/stop settle, in clocks
    localparam int LAT = 3 * SRC_DIV + 4;
    logic                 dp_q, wr_q, start_q, sec_ok_q;
    logic [7:0]           a_q, since_q;
    logic [5:0]           sec_q;
    logic [IRQ_WIDTH-1:0] mask_q;
    wire rd = dp_q && !wr_q;
    wire wd = dp_q && wr_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // ==========================================
    // Bus shadow
    always_ff @(posedge CLK) begin
        dp_q <= !RST && HSEL && HTRANS[1] && HREADYOUT;
        wr_q <= HWRITE;
        a_q  <= HADDR;
        if (RST) begin
            start_q  <= 1'b0;
            mask_q   <= '0;
            since_q  <= 8'h00;
            sec_ok_q <= 1'b0;
        end else begin
            since_q <= (wd && a_q == RTC_CTRL1_OFS && HWDATA[CTRL1_START_BIT] != start_q) ? 8'h00
                                                                                          : since_q + 8'(since_q != 8'hFF);
            if (wd && a_q == RTC_CTRL1_OFS) start_q <= HWDATA[CTRL1_START_BIT];
            if (wd && a_q == RTC_IRQMASK_OFS) mask_q <= HWDATA[IRQ_WIDTH-1:0];
            if (rd && a_q == RTC_SECONDS_OFS) sec_q <= HRDATA[5:0];
            // Any write may legally move the time, so restart the pairing
            sec_ok_q <= !wd && !start_q && since_q >= LAT && (sec_ok_q || (rd && a_q == RTC_SECONDS_OFS));
        end
    end
    // ==========================================
    // Properties
    status_set_a: assert property (rd && a_q == RTC_CTRL1_OFS && start_q && since_q >= LAT
        |-> HRDATA[CTRL1_STATUS_BIT]) else $error("status not set after start");
    status_clr_a: assert property (rd && a_q == RTC_CTRL1_OFS && !start_q && since_q >= LAT
        |-> !HRDATA[CTRL1_STATUS_BIT]) else $error("status not cleared after stop");
    stopped_hold_a: assert property (rd && a_q == RTC_SECONDS_OFS && sec_ok_q
        |-> HRDATA[5:0] == sec_q) else $error("seconds moved while stopped");
    mask_gate_a: assert property (mask_q == '0 && $past(mask_q) == '0 |-> !IRQ) else $error("masked irq");
    sec_range_a: assert property (rd && a_q == RTC_SECONDS_OFS |-> HRDATA < 32'd60) else $error("sec range");
    hour_range_a: assert property (rd && a_q == RTC_HOURS_OFS |-> HRDATA < 32'd24) else $error("hour range");
    wday_range_a: assert property (rd && a_q == RTC_WEEKDAY_OFS |-> HRDATA < 32'd7) else $error("day range");
    unmapped_zero_a: assert property (rd && a_q > RTC_IRQMASK_OFS |-> HRDATA == '0) else $error("unmapped read");
    bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus not ready or okay");
    cover property (rd && a_q == RTC_CTRL1_OFS && HRDATA[CTRL1_STATUS_BIT]);
    cover property (rd && a_q == RTC_CTRL1_OFS && HRDATA[CTRL1_BUSY_BIT]);
    cover property ($rose(IRQ));
endmodule

bind rtc_timer rtc_timer_assertions #(.SRC_DIV(SRC_DIV)) chk (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ));

// ### dv/rtc_timer_bench.sv
// Self-checking bench: registers, start/stop, carry, busy and interrupt.
// Assumes the checker is bound; shortened count source for speed.
module rtc_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;
    localparam int DIV = 2;
    localparam int SEC = 16;
    localparam int UPDATE_BUSY_FLAG = 4;
    logic        CLK = 1'b0, RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, HREADYOUT, HRESP, IRQ;
    logic [7:0]  HADDR = 8'h00;
    logic [1:0]  HTRANS = 2'h0;
    logic [2:0]  HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0, HRDATA, d, s;
    int          errors = 0, checked = 0, cyc = 0, n;
    rtc_timer #(.SRC_DIV(DIV), .SRC_SEC(SEC), .BUSY_CYC(UPDATE_BUSY_FLAG)) uut (.CLK(CLK), .RST(RST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADYOUT), .HWDATA(HWDATA),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ));
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    // ==========================================
    // Common tasks
    task automatic tally_and_finish();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp=%h got=%h", what, exp, got);
        end
    endtask
    // Single AHB transfer; read data lands in d
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wv);
        HSEL   <= 1'b1;
        HADDR  <= a;
        HWRITE <= w;
        HTRANS <= 2'h2;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        HTRANS <= 2'h0;
        HWDATA <= wv;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        d = HRDATA;
    endtask
    // Polls the status flag until it reads v, then checks it took at most DIV + 3 reads
    task automatic poll_status(input logic v);
        n = 0;
        do begin
            xfer(1'b0, RTC_CTRL1_OFS, 32'h0);
            n++;
        end while (d[CTRL1_STATUS_BIT] !== v && n < 20);
        chk("status latency", 32'h1, {31'h0, n <= DIV + 3});
    endtask
    task automatic irq_is(input logic v);
        @(posedge CLK);
        #1;
        chk("irq", {31'h0, v}, {31'h0, IRQ});
        @(posedge CLK);
    endtask
    // ==========================================
    // Scenarios
    task automatic reset_values();
        for (int i = 0; i <= 9; i++) begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", 32'h0, d);
        end
        xfer(1'b1, 8'h24, 32'hFFFFFFFF);
        xfer(1'b0, 8'h24, 32'h0);
        chk("unmapped", 32'h0, d);
    endtask
    task automatic run_and_carry();
        xfer(1'b1, RTC_SECONDS_OFS, 32'd58);
        xfer(1'b1, RTC_MINUTES_OFS, 32'd59);
        xfer(1'b1, RTC_HOURS_OFS, 32'd23);
        xfer(1'b1, RTC_WEEKDAY_OFS, 32'd6);
        xfer(1'b1, RTC_IRQMASK_OFS, 32'h1);
        xfer(1'b1, RTC_CTRL2_OFS, 32'h1);
        xfer(1'b1, RTC_CTRL1_OFS, 32'h1);
        poll_status(1'b1);
        n = 0;
        while (IRQ !== 1'b1 && n < 4 * SEC * DIV) begin
            @(posedge CLK);
            n++;
        end
        xfer(1'b0, RTC_SECONDS_OFS, 32'h0);
        chk("sec at irq", 32'd59, d);
        xfer(1'b1, RTC_IRQSTAT_OFS, 32'h3);
        do xfer(1'b0, RTC_CTRL1_OFS, 32'h0); while (d[CTRL1_BUSY_BIT] !== 1'b1 && cyc < 2900);
        n = 0;
        do begin
            xfer(1'b0, RTC_CTRL1_OFS, 32'h0);
            n++;
        end while (d[CTRL1_BUSY_BIT] === 1'b1 && n < 20);
        chk("busy span", 32'h1, {31'h0, n >= UPDATE_BUSY_FLAG * DIV / 2 && n <= UPDATE_BUSY_FLAG * DIV / 2 + 2});
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            chk("time after carry", 32'h0, d);
        end
    endtask
    task automatic irq_mask_clear();
        irq_is(1'b1);
        xfer(1'b1, RTC_IRQMASK_OFS, 32'h0);
        irq_is(1'b0);
        xfer(1'b1, RTC_IRQMASK_OFS, 32'h1);
        irq_is(1'b1);
        xfer(1'b1, RTC_IRQSTAT_OFS, 32'h3);
        irq_is(1'b0);
    endtask
    task automatic stop_and_hold();
        xfer(1'b1, RTC_CTRL1_OFS, 32'h0);
        poll_status(1'b0);
        xfer(1'b0, RTC_IRQSTAT_OFS, 32'h0);
        chk("stop done", 32'h1, {31'h0, d[IRQ_STATE_BIT]});
        repeat (2 * SEC * DIV) @(posedge CLK);
        xfer(1'b0, RTC_SECONDS_OFS, 32'h0);
        s = d;
        repeat (3 * SEC * DIV) @(posedge CLK);
        xfer(1'b0, RTC_SECONDS_OFS, 32'h0);
        chk("stopped sec", s, d);
    endtask
    // Twelve-hour mode: 11:59:59 before noon rolls to 0 with afternoon set
    task automatic twelve_hour();
        xfer(1'b1, RTC_SECONDS_OFS, 32'd59);
        xfer(1'b1, RTC_MINUTES_OFS, 32'd59);
        xfer(1'b1, RTC_HOURS_OFS, 32'd11);
        xfer(1'b1, RTC_CTRL2_OFS, 32'h0);
        xfer(1'b1, RTC_CTRL1_OFS, 32'h5);
        poll_status(1'b1);
        do xfer(1'b0, RTC_CTRL1_OFS, 32'h0); while (d[CTRL1_BUSY_BIT] !== 1'b1 && cyc < 2900);
        do xfer(1'b0, RTC_CTRL1_OFS, 32'h0); while (d[CTRL1_BUSY_BIT] === 1'b1 && cyc < 2900);
        chk("afternoon", 32'h1, {31'h0, d[CTRL1_PM_BIT]});
        xfer(1'b0, RTC_HOURS_OFS, 32'h0);
        chk("hour 12h wrap", 32'h0, d);
        xfer(1'b1, RTC_CTRL1_OFS, 32'hC);
        poll_status(1'b0);
    endtask
    initial begin
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        reset_values();
        run_and_carry();
        irq_mask_clear();
        stop_and_hold();
        twelve_hour();
        tally_and_finish();
    end
endmodule
